// ### logic/lpsc_pkg.sv
// Purpose: Constants for the low-power supply-control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
package lpsc_pkg;
   localparam logic [7:0] LPSC_SYNC_OFS = 8'h00;
   localparam logic [7:0] LPSC_CTRL_OFS = 8'h04;
   localparam logic [7:0] LPSC_MODE_OFS = 8'h08;
   localparam logic [7:0] LPSC_STAT_OFS = 8'h0C;
   localparam logic [31:0] LPSC_CTRL_RST = 32'h1FFF_8080;
   localparam logic [31:0] LPSC_SYNC_RST = 32'h0000_0000;
   localparam int LPSC_SYNC_AUTO_BIT = 2;
   localparam int LPSC_SYNC_BUSY_BIT = 1;
   localparam int LPSC_SYNC_GO_BIT = 0;
   localparam int LPSC_MANUAL_BIT = 7;
   localparam int LPSC_BANK_LSB = 24;
   localparam int LPSC_BANK_MSB = 28;
   localparam int LPSC_LP_LSB = 15;
   localparam int LPSC_LP_MSB = 23;
   localparam int LPSC_FIELD_W = 14;
   localparam logic [3:0] LPSC_SYNC_CYCLES = 4'h3;
   // Mask of fields hardware drives when manual control is off: 23:21 and 18:15
   localparam logic [8:0] LPSC_AUTO_MASK = 9'h1CF;
   localparam logic [1:0] LPSC_MODE_ACTIVE = 2'h0;
   localparam logic [1:0] LPSC_MODE_STANDBY = 2'h1;
   localparam logic [1:0] LPSC_MODE_DEEP = 2'h2;
endpackage : lpsc_pkg

// ### logic/lpsc_top.sv
// Purpose: Low-power supply-control fields with 3V-region shadow copy
// Assumes: sys_clk 40 MHz, synchronous active-high rst, APB slave
// Notes: Shadow register models the retained always-on copy
//
// Overview of operation
// - Supplies follow only the synchronized shadow copy
// - Bits 23..15 apply only in low power
// - Bit 23 keeps references and two regulators
// - Bit 22 keeps high-power regulator supplied
// - Bit 21 keeps low-power regulator supplied
// - Bit 20 keeps slow RC oscillator
// - Bit 19 keeps slow crystal oscillator
// - Bit 18 keeps fast crystal oscillator
// - Bit 17 keeps fast RC oscillator
// - Bit 16 keeps the phase-locked loop
// - Bit 15 keeps buck converter in low power
// - Auto sync, or manual go with busy flag
// - Manual off: hardware drives 23..21, 18..15
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module lpsc_top
   import lpsc_pkg::*;
(
   input wire logic sys_clk, // 40 MHz clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB write
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error for unmapped address
   output logic [1:0] power_mode, // Current mode, from mode register
   output logic poly_reference_keep, // Poly reference enable
   output logic temperature_proportional_reference_keep, // TEMPERATURE_PROPORTIONAL_REFERENCE reference enable
   output logic analog_regulator_keep, // Analog regulator enable
   output logic synthesizer_regulator_keep, // Synthesizer regulator enable
   output logic high_power_regulator_keep, // High-power regulator enable
   output logic low_power_regulator_keep, // Low-power regulator enable
   output logic slow_rc_osc_keep, // Slow RC oscillator enable
   output logic slow_crystal_keep, // Slow crystal oscillator enable
   output logic fast_crystal_keep, // Fast crystal oscillator enable
   output logic fast_rc_keep, // Fast RC oscillator enable
   output logic pll_keep, // Phase-locked loop enable
   output logic buck_keep, // Buck converter enable
   output logic [4:0] bank_memory_supply_keep // [4] link memory, [3:0] banks 3..0
);
   logic [31:0] ctrl_reg;
   logic [31:0] ctrl_next;
   logic [13:0] shadow_reg;
   logic manual_sync_reg;
   logic auto_reg;
   logic busy_reg;
   logic [3:0] sync_cnt_reg;
   logic [1:0] mode_reg;
   logic [8:0] lp_eff;
   logic [8:0] hw_default;
   logic low_power;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic go_wr;
   logic [13:0] live_fields;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign addr_ok = (paddr == LPSC_SYNC_OFS) || (paddr == LPSC_CTRL_OFS) ||
                    (paddr == LPSC_MODE_OFS) || (paddr == LPSC_STAT_OFS);
   assign go_wr = wr_en && (paddr == LPSC_SYNC_OFS) && pwdata[LPSC_SYNC_GO_BIT];
   assign live_fields = ctrl_reg[LPSC_BANK_MSB:LPSC_LP_LSB];

   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_en && paddr == LPSC_CTRL_OFS) begin
         ctrl_next = pwdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl_reg <= LPSC_CTRL_RST;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mode_reg <= LPSC_MODE_ACTIVE;
      end else if (wr_en && paddr == LPSC_MODE_OFS) begin
         mode_reg <= pwdata[1:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         auto_reg <= 1'b0;
      end else if (wr_en && paddr == LPSC_SYNC_OFS) begin
         auto_reg <= pwdata[LPSC_SYNC_AUTO_BIT];
      end
   end

   // Copy takes a few cycles, as a slow level shift into the always-on region would
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         busy_reg <= 1'b0;
         sync_cnt_reg <= 4'h0;
      end else if (busy_reg) begin
         if (sync_cnt_reg == 4'h1) begin
            busy_reg <= 1'b0;
         end
         sync_cnt_reg <= sync_cnt_reg - 4'h1;
      end else if (go_wr) begin
         busy_reg <= 1'b1;
         sync_cnt_reg <= LPSC_SYNC_CYCLES;
      end
   end

   // Shadow is the only source for supplies; an unsynced write changes nothing
   // Manual-control bit travels with the fields so it cannot act before them
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         shadow_reg <= LPSC_CTRL_RST[LPSC_BANK_MSB:LPSC_LP_LSB];
         manual_sync_reg <= LPSC_CTRL_RST[LPSC_MANUAL_BIT];
      end else if (auto_reg) begin
         shadow_reg <= live_fields;
         manual_sync_reg <= ctrl_reg[LPSC_MANUAL_BIT];
      end else if (busy_reg && sync_cnt_reg == 4'h1) begin
         shadow_reg <= live_fields;
         manual_sync_reg <= ctrl_reg[LPSC_MANUAL_BIT];
      end
   end

   assign low_power = (mode_reg == LPSC_MODE_STANDBY) || (mode_reg == LPSC_MODE_DEEP);

   // Hardware default in low power: all auto-driven sources off except slow clocks
   assign hw_default = 9'h000;

   always_comb begin
      lp_eff = shadow_reg[8:0];
      if (!manual_sync_reg) begin
         lp_eff = (shadow_reg[8:0] & ~LPSC_AUTO_MASK) | (hw_default & LPSC_AUTO_MASK);
      end
      if (!low_power) begin
         lp_eff = 9'h1FF;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         poly_reference_keep <= 1'b1;
         temperature_proportional_reference_keep <= 1'b1;
         analog_regulator_keep <= 1'b1;
         synthesizer_regulator_keep <= 1'b1;
         high_power_regulator_keep <= 1'b1;
         low_power_regulator_keep <= 1'b1;
         slow_rc_osc_keep <= 1'b1;
         slow_crystal_keep <= 1'b1;
         fast_crystal_keep <= 1'b1;
         fast_rc_keep <= 1'b1;
         pll_keep <= 1'b1;
         buck_keep <= 1'b1;
         bank_memory_supply_keep <= 5'h1F;
         power_mode <= LPSC_MODE_ACTIVE;
      end else begin
         poly_reference_keep <= lp_eff[8];
         temperature_proportional_reference_keep <= lp_eff[8];
         analog_regulator_keep <= lp_eff[8];
         synthesizer_regulator_keep <= lp_eff[8];
         high_power_regulator_keep <= lp_eff[7];
         low_power_regulator_keep <= lp_eff[6];
         slow_rc_osc_keep <= lp_eff[5];
         slow_crystal_keep <= lp_eff[4];
         fast_crystal_keep <= lp_eff[3];
         fast_rc_keep <= lp_eff[2];
         pll_keep <= lp_eff[1];
         buck_keep <= lp_eff[0];
         bank_memory_supply_keep <= shadow_reg[13:9];
         power_mode <= mode_reg;
      end
   end

   // APB: zero-wait answer, registered read data
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               LPSC_SYNC_OFS: prdata <= {29'h0, auto_reg, busy_reg, 1'b0};
               LPSC_CTRL_OFS: prdata <= ctrl_reg;
               LPSC_MODE_OFS: prdata <= {30'h0, mode_reg};
               LPSC_STAT_OFS: prdata <= {18'h0, shadow_reg};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   logic unused_ok;
   assign unused_ok = rd_en;
endmodule : lpsc_top
`default_nettype wire

// ### verif/lpsc_checker.sv
// Purpose: Port assertions for lpsc_top
// Assumes: Zero-wait APB slave, outputs settle after mode change
// Notes: Bound into every lpsc_top instance
`timescale 1ns/1ps
`default_nettype none
module lpsc_checker
   import lpsc_pkg::*;
(
   input wire logic sys_clk, // Clock
   input wire logic rst, // Reset
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Write
   input wire logic [7:0] paddr, // Address
   input wire logic [31:0] pwdata, // Write data
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic pslverr, // Error
   input wire logic [1:0] power_mode, // Mode
   input wire logic poly_reference_keep, // Reference
   input wire logic synthesizer_regulator_keep, // Regulator
   input wire logic high_power_regulator_keep, // Regulator
   input wire logic buck_keep // Buck
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   chk_ready_next: assert property (psel && !penable |=> pready) else $error("pready late");
   chk_ready_access: assert property (pready |-> psel && penable) else $error("stray pready");
   chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
   chk_unmapped_err: assert property (psel && !penable && paddr > 8'h0C |=> pslverr)
      else $error("no pslverr");
   chk_mode_write: assert property (pready && pwrite && paddr == LPSC_MODE_OFS
      |-> ##2 power_mode == $past(pwdata[1:0], 2)) else $error("mode not written");
   chk_mode_read: assert property (pready && !pwrite && paddr == LPSC_MODE_OFS
      |-> prdata == {30'h0, power_mode}) else $error("mode read wrong");
   chk_active_keep: assert property (power_mode == 2'h0 && $past(power_mode) == 2'h0
      |-> high_power_regulator_keep && buck_keep) else $error("active not kept");
   chk_ref_group: assert property (poly_reference_keep == synthesizer_regulator_keep)
      else $error("reference group split");
endmodule : lpsc_checker
bind lpsc_top lpsc_checker chk (.*);
`default_nettype wire

// ### verif/lpsc_supply_model.sv
// Purpose: Analog switch side of the supply enables
// Assumes: Each switch settles one clock after its enable moves
// Notes: Order is banks, two references and two regulators of bit 23, then bits 22 to 15
`timescale 1ns/1ps
`default_nettype none
module lpsc_supply_model (
   input wire logic sys_clk, // Clock
   input wire logic [16:0] keep_bus, // Enables
   output logic [16:0] powered // Supplies up
);
   always_ff @(posedge sys_clk) begin
      powered <= keep_bus;
   end
endmodule : lpsc_supply_model
`default_nettype wire

// ### verif/low_power_domain_supply_ctrl_tb.sv
// Purpose: Self-checking bench for lpsc_top
// Assumes: Zero-wait APB, auto sync visible within four cycles
// Notes: Expected enables recomputed from written values
`timescale 1ns/1ps
`default_nettype none
module low_power_domain_supply_ctrl_tb;
   import lpsc_pkg::*;
   logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, ctrl_m;
   logic [1:0] power_mode;
   logic [4:0] bank_memory_supply_keep;
   logic poly_reference_keep, temperature_proportional_reference_keep, analog_regulator_keep;
   logic synthesizer_regulator_keep, high_power_regulator_keep, low_power_regulator_keep;
   logic slow_rc_osc_keep, slow_crystal_keep, fast_crystal_keep, fast_rc_keep, pll_keep, buck_keep;
   logic [16:0] powered;
   int mismatches = 0, total_checks = 0, seed = 90, i;
   always #12.5 sys_clk = ~sys_clk;
   lpsc_top uut (.*);
   lpsc_supply_model sup (.sys_clk, .powered, .keep_bus({bank_memory_supply_keep,
      poly_reference_keep, temperature_proportional_reference_keep, analog_regulator_keep,
      synthesizer_regulator_keep, high_power_regulator_keep, low_power_regulator_keep,
      slow_rc_osc_keep, slow_crystal_keep, fast_crystal_keep, fast_rc_keep, pll_keep, buck_keep}));
   task automatic close_out();
      if (mismatches == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         mismatches++;
         close_out();
      end
      {rd, er} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
      @(posedge sys_clk);
   endtask : apb
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // Active mode forces every low-power field on; manual off clears hardware-owned ones
   function automatic logic [16:0] exp_keep(input logic [31:0] c, input logic [1:0] m);
      logic [8:0] f;
      f = c[23:15];
      if (m == LPSC_MODE_ACTIVE) f = 9'h1FF;
      else if (!c[LPSC_MANUAL_BIT]) f = f & ~LPSC_AUTO_MASK;
      return {c[28:24], {4{f[8]}}, f[7:0]};
   endfunction : exp_keep
   initial begin
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      apb(1'b0, LPSC_CTRL_OFS, 32'h0);
      cmp(rd, LPSC_CTRL_RST);
      cmp(32'(powered), 32'(exp_keep(LPSC_CTRL_RST, LPSC_MODE_ACTIVE)));
      apb(1'b1, LPSC_SYNC_OFS, 32'h4);
      for (i = 0; i < 12; i++) begin
         ctrl_m = $random(seed);
         apb(1'b1, LPSC_CTRL_OFS, ctrl_m);
         apb(1'b1, LPSC_MODE_OFS, 32'(i % 3));
         repeat (4) @(posedge sys_clk);
         cmp(32'(powered), 32'(exp_keep(ctrl_m, 2'(i % 3))));
         cmp(32'(power_mode), 32'(i % 3));
         apb(1'b0, LPSC_STAT_OFS, 32'h0);
         cmp(rd, {18'h0, ctrl_m[28:15]});
      end
      apb(1'b0, LPSC_MODE_OFS, 32'h0);
      cmp(rd, 32'(LPSC_MODE_DEEP));
      apb(1'b1, LPSC_SYNC_OFS, 32'h0);
      apb(1'b1, LPSC_CTRL_OFS, ~ctrl_m);
      repeat (4) @(posedge sys_clk);
      cmp(32'(powered), 32'(exp_keep(ctrl_m, LPSC_MODE_DEEP)));
      apb(1'b1, LPSC_SYNC_OFS, 32'h1);
      i = 0;
      do begin
         apb(1'b0, LPSC_SYNC_OFS, 32'h0);
         i++;
      end while (rd[LPSC_SYNC_BUSY_BIT] !== 1'b0 && i < 20);
      cmp(rd, 32'h0);
      repeat (3) @(posedge sys_clk);
      cmp(32'(powered), 32'(exp_keep(~ctrl_m, LPSC_MODE_DEEP)));
      apb(1'b1, 8'h40, 32'hFFFF_FFFF);
      cmp(32'(er), 32'h1);
      apb(1'b0, LPSC_CTRL_OFS, 32'h0);
      cmp(rd, ~ctrl_m);
      close_out();
   end
endmodule : low_power_domain_supply_ctrl_tb
`default_nettype wire
